// >>> verilog/rcs_pkg.sv
// package: register map, field layout and carrier types for recovered clock two control
package rcs_pkg;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [7:0]  RCS_CTRL_OFFS   = 8'h18;  // recovered_clock_two_control
	localparam logic [7:0]  RCS_STAT_OFFS   = 8'h1c;  // live output status
	localparam logic [15:0] RCS_CTRL_RESET  = 16'h0000;
	localparam logic [15:0] RCS_CTRL_WMASK  = 16'hff37; // bits 7:6 and 3 read-only zero

	// ------------------------------------------------------------------
	// field positions inside the control word
	// ------------------------------------------------------------------
	localparam int RCS_EN_POS    = 15;
	localparam int RCS_SRC_LSB   = 11;
	localparam int RCS_FREQ_LSB  = 8;
	localparam int RCS_LVL_LSB   = 4;
	localparam int RCS_TYPE_LSB  = 0;

	// ------------------------------------------------------------------
	// legal codes
	// ------------------------------------------------------------------
	localparam logic [3:0] RCS_SRC_MAX   = 4'h3;   // ports zero to three
	localparam logic [2:0] RCS_FREQ_25   = 3'h0;
	localparam logic [2:0] RCS_FREQ_125  = 3'h1;
	localparam logic [2:0] RCS_FREQ_3125 = 3'h2;
	localparam logic [2:0] RCS_TYPE_SER  = 3'h0;
	localparam logic [2:0] RCS_TYPE_CU   = 3'h1;
	localparam int         RCS_PORTS     = 4;
	localparam int         RCS_SYNC_W    = 25;     // six link vectors plus squelch pin

	// squelch levels
	typedef enum logic [1:0]
	{
		RCS_SQ_AUTO  = 2'h0,
		RCS_SQ_RELAX = 2'h1,
		RCS_SQ_DOWN  = 2'h2,
		RCS_SQ_OFF   = 2'h3
	} rcs_level_t;

	// control word as stored
	typedef struct packed
	{
		logic             enable;
		logic [3:0]       src;
		logic [2:0]       freq;
		rcs_level_t       level;
		logic [2:0]       ctype;
	} rcs_ctrl_t;

	// per-port link state from the phy cores
	typedef struct packed
	{
		logic [RCS_PORTS-1:0] up;
		logic [RCS_PORTS-1:0] stable;
		logic [RCS_PORTS-1:0] gig_master;
		logic [RCS_PORTS-1:0] ten_meg;
		logic [RCS_PORTS-1:0] eee;
		logic [RCS_PORTS-1:0] lp_idle;
	} rcs_link_t;

	// steering towards the clock mux
	typedef struct packed
	{
		logic       out_en;
		logic [1:0] port;
		logic [2:0] freq;
		logic       copper;
	} rcs_out_t;

endpackage

// >>> verilog/rcs_sync.sv
// two flip-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module rcs_sync
#(
	parameter int W = rcs_pkg::RCS_SYNC_W
)
(
	input  wire logic         hclk,
	input  wire logic         hresetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	import rcs_pkg::*;

	typedef struct packed
	{
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} rcs_sync_st_t;

	rcs_sync_st_t s_r;
	rcs_sync_st_t s_nxt;

	// first stage feeds only the second stage
	always_comb
	begin
		s_nxt.meta = din;
		s_nxt.sync = s_r.meta;
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign dout = s_r.sync;
endmodule

// >>> verilog/rcs_ctrl.sv
// recovered clock two control: register, squelch logic and ahb-lite slave
// What this block does
// - output driven only when enable bit set
// - source field picks port zero to three
// - frequency field picks 25, 125, 31.25 MHz
// - level 00 squelches down, unstable, master, 10M, eee
// - level 01 allows master, 10M, lp idle
// - level 10 squelches only on link down
// - level 11 never squelches automatically
// - squelch pin high forces output off
// - type field picks serial or copper clock
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module rcs_ctrl
(
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              hsel,
	input  wire logic [31:0]       haddr,
	input  wire logic [1:0]        htrans,
	input  wire logic              hwrite,
	input  wire logic [2:0]        hsize,
	input  wire logic [31:0]       hwdata,
	input  wire logic              hready,
	output logic      [31:0]       hrdata,
	output logic                   hreadyout,
	output logic                   hresp,
	input  wire rcs_pkg::rcs_link_t link_pin,
	input  wire logic              squelch_in,
	output rcs_pkg::rcs_out_t      rclk2
);
	import rcs_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed
	{
		rcs_ctrl_t   ctrl;
		logic        wr_pend;   // data phase of a write to the control word
		logic [31:0] rdata;
		logic        ready;
		rcs_out_t    out;
	} rcs_state_t;

	rcs_state_t s_r;
	rcs_state_t s_nxt;

	rcs_link_t   link;
	logic        ext_sq;
	logic [24:0] sync_q;

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	rcs_sync #(.W(RCS_SYNC_W)) u_sync
	(
		.hclk    (hclk),
		.hresetn (hresetn),
		.din     ({squelch_in, link_pin}),
		.dout    (sync_q)
	);

	assign link   = sync_q[23:0];
	assign ext_sq = sync_q[24];

	// ------------------------------------------------------------------
	// squelch decision for the selected port
	// ------------------------------------------------------------------
	logic [1:0] sel;
	logic       p_up;
	logic       p_stable;
	logic       p_gm;
	logic       p_10m;
	logic       p_eee;
	logic       p_lpi;
	logic       codes_ok;
	logic       auto_sq;
	logic       drive;

	// selected port's link vector
	always_comb
	begin
		sel      = s_r.ctrl.src[1:0];
		p_up     = link.up[sel];
		p_stable = link.stable[sel];
		p_gm     = link.gig_master[sel];
		p_10m    = link.ten_meg[sel];
		p_eee    = link.eee[sel];
		p_lpi    = link.lp_idle[sel];
	end

	// reserved codes leave the output off
	assign codes_ok = (s_r.ctrl.src <= RCS_SRC_MAX)
		&& (s_r.ctrl.freq <= RCS_FREQ_3125)
		&& (s_r.ctrl.ctype <= RCS_TYPE_CU);

	// automatic squelch per level
	always_comb
	begin
		unique case (s_r.ctrl.level)
			RCS_SQ_AUTO:  auto_sq = !p_up || !p_stable || p_gm || p_10m || p_eee;
			RCS_SQ_RELAX: auto_sq = !p_up || !p_stable || (p_eee && !p_lpi);
			RCS_SQ_DOWN:  auto_sq = !p_up;
			RCS_SQ_OFF:   auto_sq = 1'b0;
		endcase
	end

	// pin squelch overrides everything
	assign drive = s_r.ctrl.enable && codes_ok && !auto_sq && !ext_sq;

	// ------------------------------------------------------------------
	// bus slave and next state
	// ------------------------------------------------------------------
	logic        take;
	logic [15:0] cur_word;
	logic [15:0] new_word;

	assign take = hsel && htrans[1] && hready;

	always_comb
	begin
		s_nxt       = s_r;
		s_nxt.ready = 1'b1;
		cur_word    = {s_r.ctrl.enable, s_r.ctrl.src, s_r.ctrl.freq, 2'h0,
			s_r.ctrl.level, 1'b0, s_r.ctrl.ctype};
		new_word    = (cur_word & ~RCS_CTRL_WMASK) | (hwdata[15:0] & RCS_CTRL_WMASK);
		// write data phase updates the control word
		if (s_r.wr_pend)
		begin
			s_nxt.ctrl.enable = new_word[RCS_EN_POS];
			s_nxt.ctrl.src    = new_word[RCS_SRC_LSB +: 4];
			s_nxt.ctrl.freq   = new_word[RCS_FREQ_LSB +: 3];
			s_nxt.ctrl.level  = rcs_level_t'(new_word[RCS_LVL_LSB +: 2]);
			s_nxt.ctrl.ctype  = new_word[RCS_TYPE_LSB +: 3];
		end
		s_nxt.wr_pend = take && hwrite && (haddr[7:0] == RCS_CTRL_OFFS);
		// read data prepared in the address phase, forwarding a write in flight
		if (take && !hwrite)
		begin
			if (haddr[7:0] == RCS_CTRL_OFFS)
				s_nxt.rdata = {16'h0000, s_nxt.ctrl.enable, s_nxt.ctrl.src, s_nxt.ctrl.freq,
					2'h0, s_nxt.ctrl.level, 1'b0, s_nxt.ctrl.ctype};
			else if (haddr[7:0] == RCS_STAT_OFFS)
				s_nxt.rdata = {26'h0000000, ext_sq, auto_sq, codes_ok, s_r.out.out_en,
					s_r.out.copper, s_r.out.port[0]};
			else
				s_nxt.rdata = 32'h00000000;
		end
		// clock mux steering
		s_nxt.out.out_en = drive;
		s_nxt.out.port   = sel;
		s_nxt.out.freq   = s_r.ctrl.freq;
		s_nxt.out.copper = (s_r.ctrl.ctype == RCS_TYPE_CU);
	end

	// state register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s_r       <= '0;
			s_r.ctrl  <= rcs_ctrl_t'(13'h0000);
		end
		else
			s_r <= s_nxt;
	end

	assign hrdata    = s_r.rdata;
	assign hreadyout = s_r.ready;
	assign hresp     = 1'b0;
	assign rclk2     = s_r.out;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_enable_gates: assert property (!s_r.ctrl.enable |=> !rclk2.out_en)
		else $error("output on while enable clear");
	a_src_reserved: assert property (s_r.ctrl.src > RCS_SRC_MAX |=> !rclk2.out_en)
		else $error("reserved source drove output");
	a_freq_follows: assert property (rclk2.out_en |-> rclk2.freq <= RCS_FREQ_3125
		&& rclk2.freq == $past(s_r.ctrl.freq))
		else $error("bad frequency on live output");
	a_auto_master: assert property (s_r.ctrl.level == RCS_SQ_AUTO && (p_gm || p_10m || p_eee)
		|=> !rclk2.out_en)
		else $error("auto level let master or eee through");
	a_relax_master: assert property (s_r.ctrl.enable && codes_ok
		&& s_r.ctrl.level == RCS_SQ_RELAX && p_up && p_stable && p_gm && !p_eee && !ext_sq
		|=> rclk2.out_en)
		else $error("relaxed level squelched master link");
	a_down_only: assert property (s_r.ctrl.level == RCS_SQ_DOWN && !p_up |=> !rclk2.out_en)
		else $error("down level drove with link down");
	a_never_sq: assert property (s_r.ctrl.enable && codes_ok && s_r.ctrl.level == RCS_SQ_OFF
		&& !ext_sq |=> rclk2.out_en)
		else $error("off level squelched the clock");
	a_pin_squelch: assert property ($rose(squelch_in) |-> ##3 !rclk2.out_en)
		else $error("squelch pin did not force output off");
	a_type_reserved: assert property (s_r.ctrl.ctype > RCS_TYPE_CU |=> !rclk2.out_en)
		else $error("reserved type drove output");
	a_resv_zero: assert property (take && !hwrite && haddr[7:0] == RCS_CTRL_OFFS
		|=> hrdata[7:6] == 2'h0 && hrdata[3] == 1'b0 && hrdata[31:16] == 16'h0000)
		else $error("reserved bits read non-zero");

	c_write_ctrl: cover property (s_r.wr_pend ##1 rclk2.out_en);
	c_pin_kill:   cover property (rclk2.out_en ##1 ext_sq ##1 !rclk2.out_en);
	c_relax_lpi:  cover property (s_r.ctrl.level == RCS_SQ_RELAX && p_eee && p_lpi
		##1 rclk2.out_en);
endmodule

// >>> verif/test_recovered_clock_two_output_select.sv
// testbench: table-driven and directed checks of recovered clock two control
`timescale 1ns/1ps
module test_recovered_clock_two_output_select;
	import rcs_pkg::*;

	// one table row: control word, link state, squelch pin
	typedef struct packed
	{
		logic [15:0] w;
		rcs_link_t   l;
		logic        s;
	} rcs_row_t;

	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	rcs_link_t   link_pin = '0;
	logic        squelch_in = 1'b0;
	rcs_out_t    rclk2;
	logic [31:0] rd;
	int          errors = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	rcs_row_t    rows [20];

	rcs_ctrl dut_u
	(
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (3'h2),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hrdata    (hrdata),
		.hreadyout (hreadyout),
		.hresp     (hresp),
		.link_pin  (link_pin),
		.squelch_in(squelch_in),
		.rclk2     (rclk2)
	);

	// ------------------------------------------------------------------
	// clock, timeout and helpers
	// ------------------------------------------------------------------
	always #10 hclk = ~hclk;

	// cut a hang short
	always @(posedge hclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			results();
		end
	end

	task results();
		$display("checks %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one single ahb-lite transfer; read data lands in rd
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// expected steering outputs for a row
	function automatic rcs_out_t model(rcs_row_t r);
		logic [1:0] p;
		logic       q;
		rcs_out_t   o;
		p = r.w[12:11];
		case (r.w[5:4])
			2'h0: q = !r.l.up[p] | !r.l.stable[p] | r.l.gig_master[p] | r.l.ten_meg[p] | r.l.eee[p];
			2'h1: q = !r.l.up[p] | !r.l.stable[p] | (r.l.eee[p] & !r.l.lp_idle[p]);
			2'h2: q = !r.l.up[p];
			default: q = 1'b0;
		endcase
		o.out_en = r.w[15] & (r.w[14:11] <= 4'h3) & (r.w[10:8] <= 3'h2) & (r.w[2:0] <= 3'h1)
			& !q & !r.s;
		o.port = p;
		o.freq = r.w[10:8];
		o.copper = (r.w[2:0] == 3'h1);
		return o;
	endfunction

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial
	begin
		rows = '{'{16'h8000, 24'hff0000, 1'b0}, '{16'h8911, 24'hfff000, 1'b0},
			'{16'h9200, 24'hfff000, 1'b0}, '{16'h8010, 24'hff0f00, 1'b0},
			'{16'h8000, 24'hff0f00, 1'b0}, '{16'h9010, 24'hff00ff, 1'b0},
			'{16'h9010, 24'hff00f0, 1'b0}, '{16'h9220, 24'hbf0000, 1'b0},
			'{16'h9220, 24'hbff000, 1'b0}, '{16'h9230, 24'h000000, 1'b0},
			'{16'h9830, 24'h000000, 1'b0}, '{16'ha030, 24'hff0000, 1'b0},
			'{16'h8330, 24'hff0000, 1'b0}, '{16'h8032, 24'hff0000, 1'b0},
			'{16'h0030, 24'hff0000, 1'b0}, '{16'h8030, 24'hff0000, 1'b1},
			'{16'h8000, 24'hfe0000, 1'b0}, '{16'h8020, 24'hfe0000, 1'b0},
			'{16'h8a01, 24'hff0000, 1'b0}, '{16'hffff, 24'hff0000, 1'b0}};
		repeat (16) @(posedge hclk);
		chk({26'h0, rclk2}, 32'h0);
		chk({31'h0, hreadyout}, 32'h0);
		hresetn <= 1'b1;
		ahb(1'b0, RCS_CTRL_OFFS, 32'h0);
		chk(rd, 32'h0);
		$display("reset test done");
		// table: write, read back, then compare steering
		foreach (rows[i])
		begin
			link_pin <= rows[i].l;
			squelch_in <= rows[i].s;
			ahb(1'b1, RCS_CTRL_OFFS, {16'hffff, rows[i].w});
			ahb(1'b0, RCS_CTRL_OFFS, 32'h0);
			chk(rd, {16'h0, rows[i].w & 16'hff37});
			repeat (4) @(posedge hclk);
			chk({26'h0, rclk2}, {26'h0, model(rows[i])});
		end
		$display("table test done");
		// unmapped and read-only places ignore writes
		ahb(1'b1, 8'h20, 32'hffffffff);
		ahb(1'b0, 8'h20, 32'h0);
		chk(rd, 32'h0);
		ahb(1'b1, RCS_STAT_OFFS, 32'h0);
		ahb(1'b0, RCS_CTRL_OFFS, 32'h0);
		chk(rd, 32'h0000ff37);
		$display("map test done");
		// squelch pin takes effect after three edges
		ahb(1'b1, RCS_CTRL_OFFS, 32'h8000);
		repeat (4) @(posedge hclk);
		chk({31'h0, rclk2.out_en}, 32'h1);
		// status word: codes legal and output live, no squelch cause
		ahb(1'b0, RCS_STAT_OFFS, 32'h0);
		chk(rd, 32'h0000000c);
		chk({31'h0, hresp}, 32'h0);
		squelch_in <= 1'b1;
		repeat (2) @(posedge hclk);
		#1 chk({31'h0, rclk2.out_en}, 32'h1);
		@(posedge hclk);
		#1 chk({31'h0, rclk2.out_en}, 32'h0);
		// status word now shows the pin and the dead output
		ahb(1'b0, RCS_STAT_OFFS, 32'h0);
		chk(rd, 32'h00000028);
		$display("squelch pin test done");
		// reset in mid-run clears the control word
		squelch_in <= 1'b0;
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({26'h0, rclk2}, 32'h0);
		hresetn <= 1'b1;
		ahb(1'b0, RCS_CTRL_OFFS, 32'h0);
		chk(rd, 32'h0);
		$display("second reset test done");
		results();
	end
endmodule
